// File: include/rbs_pkg.sv
package rbs_pkg;
  // channel numbering
  localparam int CHAN_W = 7;
  localparam logic [6:0] CH_ADV0 = 7'h25;
  localparam logic [6:0] CH_ADV1 = 7'h26;
  localparam logic [6:0] CH_ADV2 = 7'h27;
  localparam logic [6:0] CH_DATA_LO_MAX = 7'h0a;
  localparam logic [6:0] CH_DATA_HI_MAX = 7'h24;
  localparam logic [6:0] CH_CUST_MIN = 7'h28;
  localparam logic [6:0] CH_CUST_MAX = 7'h4e;
  localparam logic [6:0] MHZ_ADV0 = 7'h02;
  localparam logic [6:0] MHZ_ADV1 = 7'h1a;
  localparam logic [6:0] MHZ_ADV2 = 7'h50;
  localparam logic [6:0] MHZ_DATA_LO_BASE = 7'h04;
  localparam logic [6:0] MHZ_DATA_HI_BASE = 7'h1c;
  localparam logic [6:0] MHZ_CUST_BASE = 7'h03;
  localparam logic [6:0] DATA_HI_FIRST = 7'h0b;
  localparam logic [6:0] WHITE_MASK = 7'h3f;
  // sequence setting encoding
  localparam logic [1:0] MODE_ALL_DEFAULT = 2'h0;
  localparam logic [1:0] MODE_DATA_USER = 2'h1;
  localparam logic [1:0] MODE_ALL_USER = 2'h2;
  localparam logic [1:0] SCHED_THREE = 2'h0;
  localparam logic [1:0] SCHED_TWO = 2'h1;
  localparam logic [1:0] SCHED_ONE = 2'h2;
  localparam int SET_MODE_LSB = 0;
  localparam int SET_SCHED_LSB = 2;
  localparam logic [4:0] SETTING_RESET = 5'h00;
  localparam int SET_SHORT_BIT = 4;
  // repeat counts per schedule
  localparam logic [2:0] GROUPS_DEFAULT = 3'h3;
  localparam logic [2:0] GROUPS_THREE = 3'h3;
  localparam logic [2:0] GROUPS_TWO = 3'h4;
  localparam logic [2:0] GROUPS_ONE = 3'h6;
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int GAP_LONG_MS = 20;
  localparam int GAP_SHORT_MS = 10;
  localparam int GAP_LONG_CYC = CLK_HZ / 1000 * GAP_LONG_MS;
  localparam int GAP_SHORT_CYC = CLK_HZ / 1000 * GAP_SHORT_MS;
  localparam int BTN_W = 4;
  localparam int ID_W = 48;
endpackage : rbs_pkg

// File: rtl/rbs_sync.sv
`timescale 1ns/1ps
module rbs_sync
  import rbs_pkg::*;
#(
  parameter int W = 1
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb
  begin
    nxt_meta = d;
    nxt_q = meta_ff;
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule : rbs_sync

// File: rtl/rbs_chan_map.sv
`timescale 1ns/1ps
module rbs_chan_map
  import rbs_pkg::*;
(
  // channel in
  input wire logic [6:0] chan,
  // results
  output logic [6:0] mhz_offset,
  output logic [6:0] white_init,
  output logic chan_valid
);
  logic [6:0] rel;

  always_comb
  begin
    rel = 7'h00;
    mhz_offset = MHZ_ADV0;
    chan_valid = 1'b1;
    if (chan == CH_ADV0)
      mhz_offset = MHZ_ADV0;
    else if (chan == CH_ADV1)
      mhz_offset = MHZ_ADV1;
    else if (chan == CH_ADV2)
      mhz_offset = MHZ_ADV2;
    else if (chan <= CH_DATA_LO_MAX)
      mhz_offset = 7'(MHZ_DATA_LO_BASE + (chan << 1));
    else if (chan <= CH_DATA_HI_MAX)
    begin
      rel = 7'(chan - DATA_HI_FIRST);
      mhz_offset = 7'(MHZ_DATA_HI_BASE + (rel << 1));
    end
    else if (chan >= CH_CUST_MIN && chan <= CH_CUST_MAX)
    begin
      rel = 7'(chan - CH_CUST_MIN);
      mhz_offset = 7'(MHZ_CUST_BASE + (rel << 1));
    end
    else
      chan_valid = 1'b0;
    // standard channels whiten with the index, custom with the offset
    // the custom offset reaches 79, so it keeps all seven bits
    if (chan >= CH_CUST_MIN)
      white_init = mhz_offset;
    else
      white_init = chan & WHITE_MASK;
  end
endmodule : rbs_chan_map

// File: rtl/rbs_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - burst on every press and every release; an edge arriving mid-burst is dropped
// - four contacts in two groups, off/on
// - default event sends 37, 38, 39 back-to-back
// - two to three default events per input
// - repeat gap 20 ms, or 10 ms optional
// - standard channel whitening seed equals index
// - custom channel seed equals MHz above 2400
// - standard channel index to frequency mapping
// - custom indices 40..78 map odd MHz
// - three modes: default, data-user, all-user
// - power-up mode is all default schedule
// - mode and user schedule from setting
// - three-channel user schedule repeated three times
// - two-channel user schedule repeated four times
// - one-channel user schedule sent six times
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter int GAP_LONG = GAP_LONG_CYC,
  parameter int GAP_SHORT = GAP_SHORT_CYC,
  parameter logic [2:0] DEFAULT_GROUPS = GROUPS_DEFAULT
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // actuator and contacts, from pins
  input wire logic bow_pushed,
  input wire logic [1:0] group_a_contacts,
  input wire logic [1:0] group_b_contacts,
  // telegram context
  input wire logic [47:0] device_id,
  input wire logic commissioning,
  // configuration
  input wire logic [4:0] sequence_setting_a,
  input wire logic [6:0] first_channel_select,
  input wire logic [6:0] second_channel_select,
  input wire logic [6:0] third_channel_select,
  // radio handshake
  output logic tx_start,
  input wire logic tx_done,
  // per-transmission data
  output logic [6:0] tx_channel,
  output logic [6:0] tx_mhz_offset,
  output logic [6:0] tx_white_init,
  output logic [3:0] tx_buttons,
  output logic tx_pressed,
  output logic tx_commissioning,
  output logic [47:0] tx_device_id,
  // status
  output logic burst_busy,
  output logic bad_channel
);
  if (GAP_SHORT < 1 || GAP_LONG < GAP_SHORT)
  begin : g_bad_gap
    $error("rbs_sequencer: gap counts out of range");
  end
  if (DEFAULT_GROUPS < 3'h2 || DEFAULT_GROUPS > 3'h3)
  begin : g_bad_groups
    $error("rbs_sequencer: default groups must be 2 or 3");
  end

  localparam int GAP_W = $clog2(GAP_LONG + 1);

  typedef enum {ST_IDLE, ST_START, ST_WAIT, ST_GAP} rbs_state_t;

  logic bow_s;
  logic [1:0] grp_a_s;
  logic [1:0] grp_b_s;

  rbs_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .d({bow_pushed, group_a_contacts, group_b_contacts}),
    .q({bow_s, grp_a_s, grp_b_s})
  );

  rbs_state_t state_ff, nxt_state;
  logic bow_prev_ff, nxt_bow_prev;
  logic [1:0] slot_ff, nxt_slot;
  logic [2:0] group_ff, nxt_group;
  logic [1:0] nslots_ff, nxt_nslots;
  logic [2:0] ngroups_ff, nxt_ngroups;
  logic user_ff, nxt_user;
  logic short_ff, nxt_short;
  logic [GAP_W-1:0] gap_ff, nxt_gap;
  logic [3:0] btn_ff, nxt_btn;
  logic pressed_ff, nxt_pressed;
  logic comm_ff, nxt_comm;
  logic [47:0] id_ff, nxt_id;
  logic [6:0] chan_ff, nxt_chan;
  logic [6:0] mhz_ff, nxt_mhz;
  logic [6:0] white_ff, nxt_white;
  logic bad_ff, nxt_bad;

  logic edge_seen;
  logic [1:0] set_mode;
  logic [1:0] set_sched;
  logic use_user;
  logic [6:0] cur_chan;
  logic [6:0] map_mhz;
  logic [6:0] map_white;
  logic map_valid;

  // a press and a release both raise a burst
  assign edge_seen = bow_s ^ bow_prev_ff;
  assign set_mode = sequence_setting_a[SET_MODE_LSB +: 2];
  assign set_sched = sequence_setting_a[SET_SCHED_LSB +: 2];

  always_comb
  begin
    unique case (set_mode)
      MODE_DATA_USER: use_user = !commissioning;
      MODE_ALL_USER: use_user = 1'b1;
      default: use_user = 1'b0;
    endcase
  end

  always_comb
  begin
    cur_chan = CH_ADV0;
    if (user_ff)
    begin
      unique case (slot_ff)
        2'h0: cur_chan = first_channel_select;
        2'h1: cur_chan = second_channel_select;
        default: cur_chan = third_channel_select;
      endcase
    end
    else
    begin
      unique case (slot_ff)
        2'h0: cur_chan = CH_ADV0;
        2'h1: cur_chan = CH_ADV1;
        default: cur_chan = CH_ADV2;
      endcase
    end
  end

  rbs_chan_map u_map (
    .chan(cur_chan),
    .mhz_offset(map_mhz),
    .white_init(map_white),
    .chan_valid(map_valid)
  );

  always_comb
  begin
    nxt_state = state_ff;
    nxt_bow_prev = bow_s;
    nxt_slot = slot_ff;
    nxt_group = group_ff;
    nxt_nslots = nslots_ff;
    nxt_ngroups = ngroups_ff;
    nxt_user = user_ff;
    nxt_short = short_ff;
    nxt_gap = gap_ff;
    nxt_btn = btn_ff;
    nxt_pressed = pressed_ff;
    nxt_comm = comm_ff;
    nxt_id = id_ff;
    nxt_chan = chan_ff;
    nxt_mhz = mhz_ff;
    nxt_white = white_ff;
    nxt_bad = bad_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (edge_seen)
        begin
          // snapshot so the whole burst repeats one identical telegram
          nxt_btn = {grp_b_s, grp_a_s};
          nxt_pressed = bow_s;
          nxt_comm = commissioning;
          nxt_id = device_id;
          nxt_user = use_user;
          nxt_short = sequence_setting_a[SET_SHORT_BIT];
          nxt_slot = 2'h0;
          nxt_group = 3'h0;
          nxt_state = ST_START;
          if (!use_user)
          begin
            nxt_nslots = 2'h2;
            nxt_ngroups = DEFAULT_GROUPS;
          end
          else
          begin
            unique case (set_sched)
              SCHED_TWO:
              begin
                nxt_nslots = 2'h1;
                nxt_ngroups = GROUPS_TWO;
              end
              SCHED_ONE:
              begin
                nxt_nslots = 2'h0;
                nxt_ngroups = GROUPS_ONE;
              end
              default:
              begin
                nxt_nslots = 2'h2;
                nxt_ngroups = GROUPS_THREE;
              end
            endcase
          end
        end
      end
      ST_START:
      begin
        nxt_chan = cur_chan;
        nxt_mhz = map_mhz;
        nxt_white = map_white;
        nxt_bad = bad_ff | !map_valid;
        nxt_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (tx_done)
        begin
          if (slot_ff != nslots_ff)
          begin
            // next channel follows with no gap
            nxt_slot = 2'(slot_ff + 2'h1);
            nxt_state = ST_START;
          end
          else if (3'(group_ff + 3'h1) == ngroups_ff)
            nxt_state = ST_IDLE;
          else
          begin
            nxt_slot = 2'h0;
            nxt_group = 3'(group_ff + 3'h1);
            nxt_gap = short_ff ? GAP_W'(GAP_SHORT - 1)
                               : GAP_W'(GAP_LONG - 1);
            nxt_state = ST_GAP;
          end
        end
      end
      ST_GAP:
      begin
        if (gap_ff == '0)
          nxt_state = ST_START;
        else
          nxt_gap = GAP_W'(gap_ff - 1'b1);
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= ST_IDLE;
      bow_prev_ff <= 1'b0;
      slot_ff <= 2'h0;
      group_ff <= 3'h0;
      nslots_ff <= 2'h2;
      ngroups_ff <= GROUPS_DEFAULT;
      user_ff <= 1'b0;
      short_ff <= 1'b0;
      gap_ff <= '0;
      btn_ff <= 4'h0;
      pressed_ff <= 1'b0;
      comm_ff <= 1'b0;
      id_ff <= 48'h0;
      chan_ff <= CH_ADV0;
      mhz_ff <= MHZ_ADV0;
      white_ff <= CH_ADV0;
      bad_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      bow_prev_ff <= nxt_bow_prev;
      slot_ff <= nxt_slot;
      group_ff <= nxt_group;
      nslots_ff <= nxt_nslots;
      ngroups_ff <= nxt_ngroups;
      user_ff <= nxt_user;
      short_ff <= nxt_short;
      gap_ff <= nxt_gap;
      btn_ff <= nxt_btn;
      pressed_ff <= nxt_pressed;
      comm_ff <= nxt_comm;
      id_ff <= nxt_id;
      chan_ff <= nxt_chan;
      mhz_ff <= nxt_mhz;
      white_ff <= nxt_white;
      bad_ff <= nxt_bad;
    end
  end

  // an edge arriving mid-burst is dropped: the harvester powers one burst
  assign tx_start = (state_ff == ST_WAIT);
  assign tx_channel = chan_ff;
  assign tx_mhz_offset = mhz_ff;
  assign tx_white_init = white_ff;
  assign tx_buttons = btn_ff;
  assign tx_pressed = pressed_ff;
  assign tx_commissioning = comm_ff;
  assign tx_device_id = id_ff;
  assign burst_busy = (state_ff != ST_IDLE);
  assign bad_channel = bad_ff;
endmodule : rbs_sequencer

// File: tb/rbs_sequencer_props.sv
`timescale 1ns/1ps
module rbs_sequencer_props
  import rbs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // radio side
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic [6:0] tx_channel,
  input wire logic [6:0] tx_mhz_offset,
  input wire logic [6:0] tx_white_init,
  input wire logic [3:0] tx_buttons,
  // status
  input wire logic burst_busy,
  input wire logic bad_channel
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  AST_DONE_DROPS: assert property (tx_start && tx_done |=> !tx_start)
    else $error("tx_start still high after tx_done");
  AST_START_BUSY: assert property ($rose(burst_busy) |->
    !tx_start ##1 tx_start)
    else $error("burst did not open with a transmission");
  AST_WHITE_STD: assert property (tx_start && tx_channel <= 7'h27 |->
    tx_white_init == tx_channel)
    else $error("standard whitening seed wrong");
  AST_WHITE_CUST: assert property (tx_start && tx_channel >= 7'h28 &&
    tx_channel <= 7'h4e |-> tx_white_init == tx_mhz_offset)
    else $error("custom whitening seed wrong");
  AST_MAP_LO: assert property (tx_start && tx_channel <= 7'h0a |->
    tx_mhz_offset == 7'h04 + (tx_channel << 1))
    else $error("low data channel frequency wrong");
  AST_MAP_HI: assert property (tx_start && tx_channel >= 7'h0b &&
    tx_channel <= 7'h24 |->
    tx_mhz_offset == 7'h1c + ((tx_channel - 7'h0b) << 1))
    else $error("high data channel frequency wrong");
  AST_MAP_CUST: assert property (tx_start && tx_channel >= 7'h28 &&
    tx_channel <= 7'h4e |->
    tx_mhz_offset == 7'h03 + ((tx_channel - 7'h28) << 1))
    else $error("custom channel frequency wrong");
  AST_MAP_ADV: assert property (tx_start && tx_channel == 7'h27 |->
    tx_mhz_offset == 7'h50)
    else $error("advertising channel frequency wrong");
  AST_BAD_FLAG: assert property (tx_start && tx_channel > 7'h4e |=>
    bad_channel)
    else $error("out of range channel not flagged");
  AST_BTN_HOLD: assert property (burst_busy && $past(burst_busy) |->
    $stable(tx_buttons))
    else $error("contact snapshot changed in a burst");
endmodule : rbs_sequencer_props

bind rbs_sequencer rbs_sequencer_props u_props (.clk_sys(clk_sys),
  .resetn(resetn), .tx_start(tx_start), .tx_done(tx_done),
  .tx_channel(tx_channel), .tx_mhz_offset(tx_mhz_offset),
  .tx_white_init(tx_white_init), .tx_buttons(tx_buttons),
  .burst_busy(burst_busy), .bad_channel(bad_channel));

// File: tb/rbs_radio_model.sv
`timescale 1ns/1ps
module rbs_radio_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // handshake
  input wire logic tx_start,
  input wire logic slow,
  output logic tx_done
);
  logic [2:0] cnt_ff;
  // slow answers keep the channel data standing for several cycles
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= 3'h0;
      tx_done <= 1'b0;
    end
    else if (!tx_start || tx_done)
    begin
      cnt_ff <= 3'h0;
      tx_done <= 1'b0;
    end
    else if (cnt_ff == (slow ? 3'h5 : 3'h0))
      tx_done <= 1'b1;
    else
      cnt_ff <= cnt_ff + 3'h1;
  end
endmodule : rbs_radio_model

// File: tb/rbs_sequencer_tb.sv
`timescale 1ns/1ps
module rbs_sequencer_tb;
  import rbs_pkg::*;
  localparam int GL = 20;
  localparam int GS = 10;
  logic clk_sys, resetn, bow_pushed, commissioning, tx_done, slow;
  logic [1:0] group_a_contacts, group_b_contacts;
  logic [47:0] device_id, tx_device_id, eid;
  logic [4:0] sequence_setting_a;
  logic [6:0] first_channel_select, second_channel_select;
  logic [6:0] third_channel_select, tx_channel, tx_mhz_offset, tx_white_init;
  logic tx_start, tx_pressed, tx_commissioning, burst_busy, bad_channel;
  logic [3:0] tx_buttons, eb;
  logic ep, ec, prev_start;
  int err_total, total_checks, seed, cyc, since;
  logic [6:0] ch_q[$];
  int dist_q[$];

  rbs_sequencer #(.GAP_LONG(GL), .GAP_SHORT(GS)) dut (.clk_sys, .resetn,
    .bow_pushed, .group_a_contacts, .group_b_contacts, .device_id,
    .commissioning, .sequence_setting_a, .first_channel_select,
    .second_channel_select, .third_channel_select, .tx_start, .tx_done,
    .tx_channel, .tx_mhz_offset, .tx_white_init, .tx_buttons, .tx_pressed,
    .tx_commissioning, .tx_device_id, .burst_busy, .bad_channel);
  rbs_radio_model u_radio (.clk_sys, .resetn, .tx_start, .slow, .tx_done);

  task automatic chk(string nm, logic [47:0] e, logic [47:0] s);
    total_checks++;
    if (e !== s)
    begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task summarize;
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // 0 means the default schedule, else channels per group
  function automatic int grp(logic [4:0] s, logic c);
    if (s[1:0] == 2'h2 || (s[1:0] == 2'h1 && !c))
      return (s[3:2] == 2'h1) ? 2 : (s[3:2] == 2'h2) ? 1 : 3;
    return 0;
  endfunction : grp

  function automatic logic [6:0] rc();
    return 7'($unsigned($random(seed)) % 79);
  endfunction : rc

  // MHz above 2400 that each index must use; 2 for an index off the table
  function automatic logic [6:0] emhz(logic [6:0] ch);
    if (ch == 7'h25)
      return 7'h02;
    if (ch == 7'h26)
      return 7'h1a;
    if (ch == 7'h27)
      return 7'h50;
    if (ch <= 7'h0a)
      return 7'(4 + 2 * ch);
    if (ch <= 7'h24)
      return 7'(6 + 2 * ch);
    if (ch <= 7'h4e)
      return 7'(2 * ch - 77);
    return 7'h02;
  endfunction : emhz

  // standard indices seed with the index, the rest with the MHz offset
  function automatic logic [6:0] ewhite(logic [6:0] ch);
    return (ch <= 7'h27) ? ch : emhz(ch);
  endfunction : ewhite

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    since <= since + 1;
    prev_start <= tx_start;
    if (tx_start && !prev_start)
      dist_q.push_back(since);
    if (tx_start && tx_done)
    begin
      ch_q.push_back(tx_channel);
      since <= 0;
      chk("buttons", eb, tx_buttons);
      chk("pressed", ep, tx_pressed);
      chk("device_id", eid, tx_device_id);
      chk("commissioning", ec, tx_commissioning);
      chk("mhz", emhz(tx_channel), tx_mhz_offset);
      chk("white", ewhite(tx_channel), tx_white_init);
    end
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  task automatic burst(logic [4:0] s, logic c, logic [6:0] c1, c2, c3);
    int g, gs, w;
    ch_q.delete();
    dist_q.delete();
    eb = 4'($random(seed));
    eid = 48'({$random(seed), $random(seed)});
    ep = !bow_pushed;
    ec = c;
    sequence_setting_a <= s;
    commissioning <= c;
    first_channel_select <= c1;
    second_channel_select <= c2;
    third_channel_select <= c3;
    {group_b_contacts, group_a_contacts} <= eb;
    device_id <= eid;
    slow <= 1'($random(seed));
    @(posedge clk_sys);
    bow_pushed <= ep;
    w = 0;
    do @(posedge clk_sys); while (!burst_busy && ++w < 20);
    while (burst_busy && w < 3000)
    begin
      @(posedge clk_sys);
      w++;
    end
    g = grp(s, c);
    gs = (g == 0) ? 3 : g;
    chk("count", (g == 1) ? 6 : (g == 2) ? 8 : 9, ch_q.size());
    foreach (ch_q[k])
      chk("channel", (g == 0) ? 7'h25 + 7'(k % 3) : (k % gs == 0) ? c1 :
        (k % gs == 1) ? c2 : c3, ch_q[k]);
    for (int k = 1; k < dist_q.size(); k++)
      chk("gap", (k % gs == 0) ? (s[4] ? GS : GL) + 1 : 1, dist_q[k]);
    repeat (3) @(posedge clk_sys);
  endtask : burst

  initial
  begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    seed = 42991;
    {resetn, bow_pushed, commissioning, slow, eb, ep, ec, eid} = '0;
    {group_a_contacts, group_b_contacts, device_id} = '0;
    {first_channel_select, second_channel_select} = '0;
    {third_channel_select, prev_start} = '0;
    sequence_setting_a = 5'h00;
    {err_total, total_checks, cyc, since} = '0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    burst(5'h00, 1'b0, rc(), rc(), rc());
    for (int i = 0; i < 16; i++)
      burst({1'($random(seed)), 2'(i), 2'(i >> 2)}, 1'($random(seed)),
        rc(), rc(), rc());
    // a corner with both custom ends and data index 0, then index 80, two past the table
    burst(5'h02, 1'b1, 7'h4e, 7'h28, 7'h00);
    chk("bad_channel", 1'b0, bad_channel);
    burst(5'h16, 1'b0, 7'h50, 7'h27, 7'h25);
    chk("bad_channel", 1'b1, bad_channel);
    summarize();
  end
endmodule : rbs_sequencer_tb
